// *** common/embhr_pkg.sv ***
// Constants, encodings and state types for the memory bus hold/release block.
// Assumes one core clock; all counts are in core clock cycles.
// What the document requires of this block and of the parts around it
// RULE1 - Burst SRAM: shared pins are address strobe, output enable, write enable.
// RULE2 - SDRAM: the same shared pins are column strobe, row strobe, write enable.
// RULE3 - First write of an adjacent run drives data one half-rate cycle early.
// RULE4 - Pending external accesses finish before the hold acknowledge goes low.
// RULE5 - With burst extension set, up to eight SDRAM accesses run before hold.
// RULE6 - With release disable set, a hold request is never granted.
// RULE7 - Idle bus on hold request is released with least latency.
// RULE8 - Bus floats no sooner than three cycles after hold request falls.
// RULE9 - Acknowledge falls with bus float, at most two cycles after.
// RULE10 - Bus drive resumes three to seven cycles after hold request rises.
// RULE11 - Acknowledge rises with bus drive, at most two cycles after.
// RULE12 - Master keeps hold request low one cycle after acknowledge falls.
// RULE13 - Released pins: selects, byte lanes, data, address, all strobes, precharge.
// RULE14 - Reset driver holds reset at least ten cycles with stable clock.
// RULE15 - Reset driver holds reset at least 250 us while the clock locks.
// RULE16 - Boot bits held five cycles around reset release; sampled at release.
// RULE17 - Expansion data pins are boot configuration inputs during reset.
// RULE18 - While hold request stays low, bus floats, acknowledge low, no access.
// RULE19 - Hold request is synchronised to the core clock before use.
`default_nettype none
package embhr_pkg;
   // Access kinds
   localparam logic [1:0] KIND_ASYNC = 2'h0;
   localparam logic [1:0] KIND_BURST_SRAM_MODE = 2'h1;
   localparam logic [1:0] KIND_SDRAM = 2'h2;
   // Shared control pin positions (burst SRAM name / SDRAM name)
   localparam int CTL_ADS_CAS = 0; // burst_addr_strobe / sdram_col_strobe
   localparam int CTL_OE_RAS = 1; // burst_out_enable / sdram_row_strobe
   localparam int CTL_WE_WE = 2; // burst_write_enable / sdram_write_enable
   localparam logic [2:0] CTL_IDLE = 3'h7;
   // Widths
   localparam int ADDR_W = 20;
   localparam int DATA_W = 32;
   // Timing counts in core cycles
   localparam logic [3:0] HOLD_BURST_MAX = 4'h8;
   localparam logic [2:0] ASYNC_STROBE_CYC = 3'h4;
   localparam logic [2:0] SYNC_CMD_CYC = 3'h2; // one half-rate clock period
   localparam logic [2:0] EARLY_DATA_CYC = 3'h2; // one half-rate clock period
   localparam logic [DATA_W-1:0] BOOT_CFG_RST = 32'h0000_0000;
   // Hold arbiter states
   typedef enum logic [3:0] {
      HOLD_RUN = 4'b0001,
      HOLD_DRAIN = 4'b0010,
      HOLD_HELD = 4'b0100,
      HOLD_RESUME = 4'b1000
   } embhr_hold_e;
   // Access sequencer states
   typedef enum logic [4:0] {
      SEQ_IDLE = 5'b00001,
      SEQ_LEAD = 5'b00010,
      SEQ_CMD = 5'b00100,
      SEQ_STROBE = 5'b01000,
      SEQ_TAIL = 5'b10000
   } embhr_seq_e;
   // Three-stage synchroniser decision: change only when stages 2 and 3 agree
   function automatic logic sync_agree(input logic s2, input logic s3,
                                       input logic prev);
      sync_agree = (s2 == s3) ? s3 : prev;
   endfunction
endpackage
`default_nettype wire

// *** common/embhr_seq_if.sv ***
// Carrier between the hold arbiter and the access sequencer.
// Assumes both ends run on the core clock.
`default_nettype none
interface embhr_seq_if;
   import embhr_pkg::*;
   logic start;
   logic [1:0] kind;
   logic write;
   logic first_write;
   logic precharge;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic [3:0] be;
   logic [3:0] ce;
   logic [DATA_W-1:0] pin_rdata;
   logic ready_ok;
   logic busy;
   logic done;
   logic [DATA_W-1:0] rdata;
   logic [2:0] ctl_n;
   logic async_re_n;
   logic async_oe_n;
   logic async_we_n;
   logic [3:0] ce_n;
   logic [3:0] be_n;
   logic [ADDR_W-1:0] pin_addr;
   logic [DATA_W-1:0] pin_wdata;
   logic data_en;
   logic sdram_a10;
   logic half_clk;
   modport arb (output start, kind, write, first_write, precharge, addr,
      wdata, be, ce, pin_rdata, ready_ok, input busy, done, rdata, ctl_n,
      async_re_n, async_oe_n, async_we_n, ce_n, be_n, pin_addr, pin_wdata,
      data_en, sdram_a10, half_clk);
   modport seq (input start, kind, write, first_write, precharge, addr,
      wdata, be, ce, pin_rdata, ready_ok, output busy, done, rdata, ctl_n,
      async_re_n, async_oe_n, async_we_n, ce_n, be_n, pin_addr, pin_wdata,
      data_en, sdram_a10, half_clk);
endinterface
`default_nettype wire

// *** design/embhr_access_seq.sv ***
// Access sequencer: runs one external access and drives the pin values.
// Assumes the arbiter only starts an access while busy is low.
`default_nettype none
module embhr_access_seq (
   input wire logic i_core_clk, // Core clock
   input wire logic i_sys_rst, // Synchronous reset, high
   input wire logic i_clk_en, // Freezes all state when low
   embhr_seq_if.seq bus // Arbiter side
);
   import embhr_pkg::*;
   embhr_seq_e state;
   logic [2:0] cnt;
   logic is_write;
   logic [1:0] cur_kind;

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst);

   assign bus.busy = (state != SEQ_IDLE);

   // Half-rate output clock, free running
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) bus.half_clk <= 1'b0;
      else if (i_clk_en) bus.half_clk <= ~bus.half_clk;
   end

   // Sequence state, counters and strobes
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         state <= SEQ_IDLE;
         cnt <= 3'h0;
         is_write <= 1'b0;
         cur_kind <= KIND_ASYNC;
         bus.done <= 1'b0;
         bus.ctl_n <= CTL_IDLE;
         bus.async_re_n <= 1'b1;
         bus.async_oe_n <= 1'b1;
         bus.async_we_n <= 1'b1;
         bus.data_en <= 1'b0;
      end else if (i_clk_en) begin
         bus.done <= 1'b0;
         unique case (state)
            SEQ_IDLE: begin
               if (bus.start) begin
                  is_write <= bus.write;
                  cur_kind <= bus.kind;
                  bus.data_en <= bus.write;
                  if (bus.kind == KIND_ASYNC) begin
                     state <= SEQ_STROBE;
                     cnt <= ASYNC_STROBE_CYC - 3'h1;
                     bus.async_re_n <= bus.write;
                     bus.async_oe_n <= bus.write;
                     bus.async_we_n <= ~bus.write;
                  end else if (bus.write && bus.first_write) begin
                     // Data leads the command to cover driver turn-on
                     state <= SEQ_LEAD; // [RULE3]
                     cnt <= EARLY_DATA_CYC - 3'h1;
                  end else begin
                     state <= SEQ_CMD;
                     cnt <= SYNC_CMD_CYC - 3'h1;
                     bus.ctl_n[CTL_ADS_CAS] <= 1'b0; // [RULE1] [RULE2]
                     bus.ctl_n[CTL_OE_RAS] <= bus.write ||
                        (bus.kind == KIND_SDRAM); // [RULE1] [RULE2]
                     bus.ctl_n[CTL_WE_WE] <= ~bus.write; // [RULE1] [RULE2]
                  end
               end
            end
            SEQ_LEAD: begin
               if (cnt != 3'h0) cnt <= cnt - 3'h1;
               else begin
                  state <= SEQ_CMD;
                  cnt <= SYNC_CMD_CYC - 3'h1;
                  bus.ctl_n[CTL_ADS_CAS] <= 1'b0; // [RULE1] [RULE2]
                  bus.ctl_n[CTL_OE_RAS] <= 1'b1; // Write: no OE, no RAS
                  bus.ctl_n[CTL_WE_WE] <= 1'b0; // [RULE1] [RULE2]
               end
            end
            SEQ_CMD: begin
               if (cnt != 3'h0) cnt <= cnt - 3'h1;
               else begin
                  state <= SEQ_IDLE;
                  bus.ctl_n <= CTL_IDLE;
                  bus.data_en <= 1'b0;
                  bus.done <= 1'b1;
               end
            end
            SEQ_STROBE: begin
               // Strobe is stretched while the ready pin stays low
               if (cnt != 3'h0) cnt <= cnt - 3'h1;
               else if (bus.ready_ok) begin
                  state <= SEQ_TAIL;
                  bus.async_re_n <= 1'b1;
                  bus.async_oe_n <= 1'b1;
                  bus.async_we_n <= 1'b1;
               end
            end
            SEQ_TAIL: begin
               state <= SEQ_IDLE;
               bus.data_en <= 1'b0;
               bus.done <= 1'b1;
            end
         endcase
      end
   end

   // Address, selects and write data held for the whole access
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         bus.pin_addr <= '0;
         bus.pin_wdata <= '0;
         bus.ce_n <= 4'hf;
         bus.be_n <= 4'hf;
         bus.sdram_a10 <= 1'b0;
      end else if (i_clk_en) begin
         if (state == SEQ_IDLE && bus.start) begin
            bus.pin_addr <= bus.addr;
            bus.pin_wdata <= bus.wdata;
            bus.ce_n <= ~bus.ce;
            bus.be_n <= ~bus.be;
            bus.sdram_a10 <= bus.precharge && (bus.kind == KIND_SDRAM);
         end else if (bus.done) begin
            bus.ce_n <= 4'hf;
            bus.be_n <= 4'hf;
         end
      end
   end

   // Read data captured at the end of a read
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) bus.rdata <= '0;
      else if (i_clk_en && !is_write &&
               ((state == SEQ_CMD && cnt == 3'h0) ||
                state == SEQ_TAIL)) bus.rdata <= bus.pin_rdata;
   end

   lead_data_on_a: assert property ( // [RULE3]
      state == SEQ_LEAD |-> bus.data_en && bus.ctl_n == CTL_IDLE)
      else $error("early write data not driven ahead of command");
   burst_read_pins_a: assert property ( // [RULE1]
      state == SEQ_CMD && !is_write && cur_kind == KIND_BURST_SRAM_MODE |->
      bus.ctl_n == 3'h4)
      else $error("burst SRAM read strobes wrong");
   sdram_write_pins_a: assert property ( // [RULE2]
      state == SEQ_CMD && is_write && cur_kind == KIND_SDRAM |->
      bus.ctl_n == 3'h2)
      else $error("SDRAM write strobes wrong");
endmodule
`default_nettype wire

// *** design/embhr_hold_release.sv ***
// Memory bus hold/release arbiter with pin drive and boot bit capture.
// Assumes an internal controller offering accesses on a valid/ready port,
// and that the testbench resolves the pins from the output enables.
`default_nettype none
module embhr_hold_release (
   input wire logic i_core_clk, // Core clock, 20 MHz
   input wire logic i_sys_rst, // Synchronous reset, high
   input wire logic i_clk_en, // Freezes all state when low
   input wire logic i_hold_req_n, // Hold request pin, low asks
   output logic o_bus_release_ack_n, // Hold acknowledge, low grants
   input wire logic i_release_disable_bit, // 1: never grant hold
   input wire logic i_sdram_burst_extend_bit, // 1: SDRAM run before hold
   input wire logic i_async_ready, // Async ready pin, high ends strobe
   input wire logic [31:0] i_expansion_data_pins, // Boot bits in reset
   output logic [31:0] o_boot_config, // Boot bits caught at release
   input wire logic i_acc_valid, // Access request valid
   output logic o_acc_ready, // Access request taken
   input wire logic [1:0] i_acc_kind, // embhr_pkg::KIND_* code
   input wire logic i_acc_write, // 1 write, 0 read
   input wire logic [embhr_pkg::ADDR_W-1:0] i_acc_addr, // Word address
   input wire logic [embhr_pkg::DATA_W-1:0] i_acc_wdata, // Write data
   input wire logic [3:0] i_acc_be, // Byte lanes, high active
   input wire logic [3:0] i_acc_ce, // Chip select, high active
   input wire logic i_acc_precharge, // SDRAM auto-precharge request
   output logic o_acc_done, // One-cycle pulse, access finished
   output logic [embhr_pkg::DATA_W-1:0] o_acc_rdata, // Read data
   output logic [3:0] o_chip_enable_n, // Chip enables
   output logic [3:0] o_byte_select_lines_n, // Byte enables
   output logic [embhr_pkg::ADDR_W-1:0] o_mem_addr_pins, // Address 21:2
   output logic [embhr_pkg::DATA_W-1:0] o_mem_data_pins, // Data out
   input wire logic [embhr_pkg::DATA_W-1:0] i_mem_data_pins, // Data in
   output logic o_mem_data_oe, // Data pins driven
   output logic o_async_read_strobe_n, // Async read strobe
   output logic o_async_out_enable_n, // Async output enable
   output logic o_async_write_strobe_n, // Async write strobe
   output logic [2:0] o_shared_ctl_n, // Shared synchronous strobes
   output logic o_sdram_autoprecharge_line, // SDRAM precharge address
   output logic o_mem_ctl_oe, // All released pins but data driven
   output logic o_half_rate_out_clock // Half-rate output clock
);
   import embhr_pkg::*;
   embhr_hold_e state;
   embhr_hold_e next_state;
   logic hold_s1, hold_s2, hold_s3, hold_n_ok;
   logic rdy_s1, rdy_s2, rdy_s3, rdy_ok;
   logic [DATA_W-1:0] xd_s1, xd_s2, xd_s3;
   logic [DATA_W-1:0] md_s1, md_s2, md_s3;
   logic rst_q;
   logic drive;
   logic ack;
   logic [3:0] burst_cnt;
   logic accept;
   logic hold_ask;
   logic drain_more;
   logic last_write;
   logic [ADDR_W-1:0] last_addr;
   logic [1:0] last_kind;

   embhr_seq_if sq ();

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst);

   // Pin synchronisers; stage 1 feeds stage 2 only
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         hold_s1 <= 1'b1;
         hold_s2 <= 1'b1;
         hold_s3 <= 1'b1;
         hold_n_ok <= 1'b1;
      end else if (i_clk_en) begin
         hold_s1 <= i_hold_req_n; // [RULE19]
         hold_s2 <= hold_s1;
         hold_s3 <= hold_s2;
         hold_n_ok <= sync_agree(hold_s2, hold_s3, hold_n_ok); // [RULE19]
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         rdy_s1 <= 1'b0;
         rdy_s2 <= 1'b0;
         rdy_s3 <= 1'b0;
         rdy_ok <= 1'b0;
      end else if (i_clk_en) begin
         rdy_s1 <= i_async_ready;
         rdy_s2 <= rdy_s1;
         rdy_s3 <= rdy_s2;
         rdy_ok <= sync_agree(rdy_s2, rdy_s3, rdy_ok);
      end
   end

   // Data pin stages carry no reset; they must keep sampling through reset
   // so the boot bits are already settled at release
   always_ff @(posedge i_core_clk) begin
      if (i_clk_en) begin
         xd_s1 <= i_expansion_data_pins; // [RULE17]
         xd_s2 <= xd_s1;
         xd_s3 <= xd_s2;
         md_s1 <= i_mem_data_pins;
         md_s2 <= md_s1;
         md_s3 <= md_s2;
      end
   end

   // Boot bits caught on the first edge after reset release
   always_ff @(posedge i_core_clk) begin
      if (i_clk_en) rst_q <= i_sys_rst;
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) o_boot_config <= BOOT_CFG_RST;
      else if (i_clk_en && rst_q) o_boot_config <= xd_s3; // [RULE16]
   end

   // Request admission: a grant that is due stops new accesses
   assign hold_ask = !hold_n_ok && !i_release_disable_bit; // [RULE6]
   assign drain_more = i_sdram_burst_extend_bit && (i_acc_kind == KIND_SDRAM)
      && (last_kind == KIND_SDRAM) && (burst_cnt < HOLD_BURST_MAX); // [RULE5]
   always_comb begin
      o_acc_ready = 1'b0;
      if (!i_sys_rst && !sq.busy) begin
         if (state == HOLD_RUN) o_acc_ready = !hold_ask;
         else if (state == HOLD_DRAIN) o_acc_ready = drain_more; // [RULE5]
      end
   end
   assign accept = i_acc_valid && o_acc_ready && i_clk_en;

   // Next hold state
   always_comb begin
      next_state = state;
      unique case (state)
         HOLD_RUN: begin
            // Idle bus goes straight to release
            if (hold_ask && !sq.busy) next_state = HOLD_HELD; // [RULE7]
            else if (hold_ask) next_state = HOLD_DRAIN; // [RULE4]
         end
         HOLD_DRAIN: begin
            if (!sq.busy && !accept) next_state = HOLD_HELD; // [RULE4]
         end
         HOLD_HELD: begin
            if (hold_n_ok) next_state = HOLD_RESUME; // [RULE18]
         end
         HOLD_RESUME: next_state = HOLD_RUN;
      endcase
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) state <= HOLD_RUN;
      else if (i_clk_en) state <= next_state;
   end

   // Bus drive and acknowledge move on the same edge at float; the
   // acknowledge trails drive by one edge when the bus comes back
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) drive <= 1'b0;
      else if (i_clk_en) drive <= (next_state != HOLD_HELD); // [RULE8] [RULE10]
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) ack <= 1'b0;
      else if (i_clk_en) ack <= (next_state == HOLD_HELD) ||
                               (state == HOLD_HELD); // [RULE9] [RULE11]
   end
   assign o_bus_release_ack_n = ~ack;

   // SDRAM accesses counted since the hold request was seen
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) burst_cnt <= 4'h0;
      else if (i_clk_en) begin
         if (state == HOLD_RUN && next_state == HOLD_DRAIN) burst_cnt <= 4'h1;
         else if (state == HOLD_DRAIN && accept)
            burst_cnt <= burst_cnt + 4'h1; // [RULE5]
      end
   end

   // Run tracking for the early write data
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         last_write <= 1'b0;
         last_addr <= '0;
         last_kind <= KIND_ASYNC;
      end else if (i_clk_en) begin
         if (accept) begin
            last_write <= i_acc_write;
            last_addr <= i_acc_addr;
            last_kind <= i_acc_kind;
         end else if (!sq.busy && !sq.done) last_write <= 1'b0; // Run broken
      end
   end

   // Sequencer hookup
   assign sq.start = accept;
   assign sq.kind = i_acc_kind;
   assign sq.write = i_acc_write;
   assign sq.first_write = !(last_write && sq.done &&
      (i_acc_addr == last_addr + 20'h00001)); // [RULE3]
   assign sq.precharge = i_acc_precharge;
   assign sq.addr = i_acc_addr;
   assign sq.wdata = i_acc_wdata;
   assign sq.be = i_acc_be;
   assign sq.ce = i_acc_ce;
   assign sq.pin_rdata = md_s3;
   assign sq.ready_ok = rdy_ok;

   embhr_access_seq u_seq (
      .i_core_clk (i_core_clk),
      .i_sys_rst (i_sys_rst),
      .i_clk_en (i_clk_en),
      .bus (sq.seq)
   );

   // Pin outputs; every released pin shares the drive flag
   assign o_acc_done = sq.done;
   assign o_acc_rdata = sq.rdata;
   assign o_chip_enable_n = sq.ce_n;
   assign o_byte_select_lines_n = sq.be_n;
   assign o_mem_addr_pins = sq.pin_addr;
   assign o_mem_data_pins = sq.pin_wdata;
   assign o_mem_data_oe = drive && sq.data_en; // [RULE13]
   assign o_async_read_strobe_n = sq.async_re_n;
   assign o_async_out_enable_n = sq.async_oe_n;
   assign o_async_write_strobe_n = sq.async_we_n;
   assign o_shared_ctl_n = sq.ctl_n;
   assign o_sdram_autoprecharge_line = sq.sdram_a10;
   assign o_mem_ctl_oe = drive; // [RULE13]
   assign o_half_rate_out_clock = sq.half_clk;

   drain_before_ack_a: assert property ( // [RULE4]
      $rose(ack) |-> !$past(sq.busy))
      else $error("acknowledge while an access was still running");
   float_delay_a: assert property ( // [RULE8]
      $fell(drive) |-> !$past(i_hold_req_n, 3) && !$past(i_hold_req_n, 2))
      else $error("bus floated too soon after hold request");
   ack_with_float_a: assert property ( // [RULE9]
      $fell(drive) |-> ack)
      else $error("acknowledge not given with bus float");
   resume_window_a: assert property ( // [RULE10]
      state == HOLD_HELD && $rose(i_hold_req_n) && i_clk_en |->
      ##[3:6] drive)
      else $error("bus drive not resumed in time");
   ack_after_drive_a: assert property ( // [RULE11]
      $rose(drive) && ack |=> !ack)
      else $error("acknowledge not withdrawn after bus drive");
   held_quiet_a: assert property ( // [RULE18]
      state == HOLD_HELD |-> !drive && ack && !o_acc_ready && !o_mem_data_oe)
      else $error("bus active during hold");
   idle_release_a: assert property ( // [RULE7]
      state == HOLD_RUN && hold_ask && !sq.busy && i_clk_en |=>
      state == HOLD_HELD && !drive)
      else $error("idle bus not released at once");
   no_hold_a: assert property ( // [RULE6]
      state == HOLD_RUN && i_release_disable_bit |=> state != HOLD_HELD)
      else $error("hold granted while disabled");
   burst_limit_a: assert property ( // [RULE5]
      state == HOLD_DRAIN |-> burst_cnt <= HOLD_BURST_MAX)
      else $error("too many SDRAM accesses before hold");
   boot_capture_a: assert property ( // [RULE16]
      rst_q && i_clk_en |=> o_boot_config == $past(xd_s3))
      else $error("boot bits not caught at reset release");
endmodule
`default_nettype wire

// *** testbench/embhr_master_model.sv ***
// Outside master that borrows the memory bus through the hold handshake.
// Assumes the bench asks through i_want and the device answers on i_ack_n.
`default_nettype none
module embhr_master_model (
   input wire logic i_core_clk, // Core clock
   input wire logic i_want, // Bench wants the bus
   input wire logic i_ack_n, // Hold acknowledge from the device
   output logic o_hold_req_n // Hold request pin
);
   timeunit 1ns;
   timeprecision 1ns;
   logic granted = 1'b0;
   initial o_hold_req_n = 1'b1;
   // Once granted, the request stays low one more full cycle
   always @(posedge i_core_clk) begin
      granted <= (i_ack_n === 1'b0);
      if (i_want) begin
         o_hold_req_n <= 1'b0;
      end else if (granted || i_ack_n !== 1'b0) begin
         o_hold_req_n <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// *** testbench/external_memory_bus_hold_release_bench.sv ***
// Bench for the hold/release block: random accesses, hold and reset.
// Assumes the master model answers the hold handshake.
`default_nettype none
module external_memory_bus_hold_release_bench;
   import embhr_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, rst = 1'b1, want = 1'b0, dis = 1'b0, ext = 1'b0;
   logic rdy = 1'b1, valid = 1'b0, wr = 1'b0, pre = 1'b0;
   logic hold_n, ack_n, ready, done, ctl_oe, data_oe;
   logic [1:0] kind = 2'h0;
   logic [2:0] ctl_n;
   logic [3:0] be = 4'hf, ce = 4'h1;
   logic [4:0] mon;
   logic [19:0] addr = 20'h0;
   logic [31:0] xd = 32'h0, wdata = 32'h0, mdin = 32'h0, boot, dout;
   int failures = 0, comparisons = 0;
   assign mon = {ready, done, ack_n, ctl_oe, hold_n};
   always #25 clk = ~clk;
   embhr_hold_release dut_u (.i_core_clk(clk), .i_sys_rst(rst),
      .i_clk_en(1'b1), .i_hold_req_n(hold_n), .o_bus_release_ack_n(ack_n),
      .i_release_disable_bit(dis), .i_sdram_burst_extend_bit(ext),
      .i_async_ready(rdy), .i_expansion_data_pins(xd),
      .o_boot_config(boot), .i_acc_valid(valid), .o_acc_ready(ready),
      .i_acc_kind(kind), .i_acc_write(wr), .i_acc_addr(addr),
      .i_acc_wdata(wdata), .i_acc_be(be), .i_acc_ce(ce),
      .i_acc_precharge(pre), .o_acc_done(done), .o_acc_rdata(),
      .o_chip_enable_n(), .o_byte_select_lines_n(), .o_mem_addr_pins(),
      .o_mem_data_pins(dout), .i_mem_data_pins(mdin),
      .o_mem_data_oe(data_oe), .o_async_read_strobe_n(),
      .o_async_out_enable_n(), .o_async_write_strobe_n(),
      .o_shared_ctl_n(ctl_n), .o_sdram_autoprecharge_line(),
      .o_mem_ctl_oe(ctl_oe), .o_half_rate_out_clock());
   embhr_master_model master_u (.i_core_clk(clk), .i_want(want),
      .i_ack_n(ack_n), .o_hold_req_n(hold_n));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      if (failures == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Active-low shared strobes expected for a read or write command
   function automatic logic [31:0] cmd_of(input logic [1:0] k,
                                          input logic w);
      cmd_of = w ? 32'h2 : (k == KIND_SDRAM ? 32'h6 : 32'h4);
   endfunction
   // Counts falling edges until a watched signal reaches a level
   task automatic await(input int b, input logic v, output int n);
      n = 0;
      while (mon[b] !== v && n < 300) begin
         @(negedge clk);
         n++;
      end
   endtask
   // Offers one access and follows it to its done pulse
   task automatic issue(input logic [1:0] k, input logic w,
                        input logic [19:0] a, output int lead);
      int n;
      logic [2:0] cmd;
      lead = 0;
      cmd = CTL_IDLE;
      valid = 1'b1;
      kind = k;
      wr = w;
      addr = a;
      wdata = $urandom;
      mdin = $urandom;
      {pre, be, ce} = 9'($urandom);
      await(4, 1'b1, n);
      @(negedge clk);
      valid = 1'b0;
      while (done !== 1'b1 && n < 300) begin
         check(ack_n, 1'b1);
         if (data_oe === 1'b1 && ctl_n === CTL_IDLE && cmd === CTL_IDLE) begin
            lead++;
            check(dout, wdata);
         end
         if (ctl_n !== CTL_IDLE && cmd === CTL_IDLE) begin
            cmd = ctl_n;
         end
         rdy = 1'($urandom_range(0, 1));
         @(negedge clk);
         n++;
      end
      check(done, 1'b1);
      if (k != KIND_ASYNC) begin
         check(cmd, cmd_of(k, w));
      end
   endtask
   // Lends the bus for a few cycles and times both hand-overs
   task automatic hold_cycle(input logic idle);
      int n;
      want <= 1'b1;
      await(0, 1'b0, n);
      await(1, 1'b0, n);
      check(n >= 3, 1'b1);
      if (idle) begin
         // Three sync flops, the agreement flop, then the state edge
         check(n, 5);
      end
      check(ack_n, 1'b0);
      repeat ($urandom_range(2, 9)) begin
         check({ctl_oe, data_oe, ack_n, ready}, 4'h0);
         @(negedge clk);
      end
      want <= 1'b0;
      await(0, 1'b1, n);
      await(1, 1'b1, n);
      check(n >= 3 && n <= 7, 1'b1);
      await(2, 1'b1, n);
      check(n <= 2, 1'b1);
   endtask
   // Boot bits must be caught at release and then ignored
   task automatic do_reset();
      rst = 1'b1;
      xd = $urandom;
      // Clock is stable from the start, so no lock-time reset is owed
      repeat (10) @(negedge clk);
      rst = 1'b0;
      repeat (5) @(negedge clk);
      check(boot, xd);
      xd = ~xd;
      repeat (5) @(negedge clk);
      check(boot, ~xd);
   endtask
   initial begin
      #(50 * 20000);
      failures++;
      summarize();
   end
   initial begin
      int lead;
      logic [19:0] a;
      void'($urandom(73443));
      do_reset();
      // Both synchronous kinds, reads and adjacent write pairs
      for (int i = 0; i < 8; i++) begin
         a = 20'($urandom);
         issue(i[0] ? KIND_SDRAM : KIND_BURST_SRAM_MODE, i[1], a, lead);
         check(lead, {30'h0, i[1], 1'b0});
         if (i[1]) begin
            issue(kind, 1'b1, a + 20'h1, lead);
            check(lead, 0);
         end
      end
      hold_cycle(1'b1);
      // Hold asked while a ready-stretched access runs
      fork
         issue(KIND_ASYNC, 1'($urandom), a, lead);
         hold_cycle(1'b0);
      join
      // SDRAM stream continuing into a pending hold
      ext <= 1'b1;
      fork
         repeat (3) issue(KIND_SDRAM, 1'b0, 20'($urandom), lead);
         hold_cycle(1'b0);
      join
      ext <= 1'b0;
      dis <= 1'b1;
      want <= 1'b1;
      repeat (20) begin
         @(negedge clk);
         check({ack_n, ctl_oe}, 2'h3);
      end
      want <= 1'b0;
      repeat (8) @(negedge clk);
      dis <= 1'b0;
      do_reset();
      hold_cycle(1'b1);
      summarize();
   end
endmodule
`default_nettype wire
